// ### src/tos_top.sv
// option and status flag logic of a 16-bit multi-mode timer, AXI4-Lite reachable
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`default_nettype none
`include "tos_regs.svh"

// How it works
// - b register capture select, free-run only
// - a register capture select, free-run only
// - up wrap in free-run, pulse-width or offset mode sets overflow flag, interrupts
// - writing 0 clears flag and counter
// - no overflow on FFFF compare clear
// - reads keep flag, writing 1 ignored
// - byte and single-bit accesses supported
// - encoder status valid only in encoder modes
// - encoder down wrap sets underflow flag
// - encoder up wrap sets encoder overflow
// - encoder flags cleared by 0 or stop
// - hold keeps encoder flags over stop
// - reads keep encoder flags, 1 ignored
// - direction flag 0 up, 1 down
// - reload status zero outside reload modes
// - b register write sets pending, reload clears
// - all three registers reset to zero
// - hold keeps counter, resumes on enable
module tos_top
    import tos_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // register bus
    input wire tos_axil_req_s axi_req,
    output tos_axil_rsp_s axi_rsp,
    // timer datapath events
    input wire tos_evt_s evt,
    // timer outputs
    output logic overflow_interrupt,
    output logic ccr_a_capture,
    output logic ccr_b_capture,
    output logic [CNT_W-1:0] count_value
);
    if (CNT_W != 16)
    begin : g_chk
        $error("tos_top serves a 16-bit counter only");
    end

    // ****************************************
    // bus state
    // ****************************************
    tos_wr_e wr_st_q;
    tos_rd_e rd_st_q;
    logic aw_got_q;
    logic w_got_q;
    logic [31:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_go;
    logic [2:0] aw_hit;

    // ****************************************
    // register state
    // ****************************************
    logic ccs0_q;
    logic ccs1_q;
    logic esf_q;
    logic [7:0] ctrl_q;
    logic int_q;
    logic cap_a_q;
    logic cap_b_q;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;
    logic [3:0] flag_q;
    logic [CNT_W-1:0] cnt;
    logic wrap_up;
    logic wrap_down;

    // flag bank order
    localparam int F_OVF = 0;
    localparam int F_EOF = 1;
    localparam int F_EUF = 2;
    localparam int F_RSF = 3;

    logic run;
    logic hold;
    logic rld;
    logic [3:0] mode;
    logic enc;
    logic ovm;
    logic stop_clr;
    logic wr_opt0;
    logic wr_opt1;
    logic wr_ctrl;
    logic ovf_wclr;
    logic cnt_clr;

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic [2:0] dec(input logic [31:0] a);
        logic [2:0] hit;
        hit = 3'h0;
        hit[0] = a[31:2] == 30'(`TOS_OPT0_IDX);
        hit[1] = a[31:2] == 30'(`TOS_OPT1_IDX);
        hit[2] = a[31:2] == 30'(`TOS_OPT2_IDX);
        return hit;
    endfunction

    function automatic logic mapped(input logic [31:0] a);
        return (|dec(a)) || a[31:2] == 30'(`TOS_CTRL_ADDR >> 2)
            || a[31:2] == 30'(`TOS_CNT_ADDR >> 2);
    endfunction

    assign run = ctrl_q[`TOS_RUN_BIT];
    assign hold = ctrl_q[`TOS_HOLD_BIT];
    assign rld = ctrl_q[`TOS_RLD_BIT];
    assign mode = ctrl_q[`TOS_MODE_LSB +: 4];
    assign enc = tos_is_encoder(mode);
    assign ovm = tos_is_ovf_mode(mode);
    assign stop_clr = !run && !hold;

    // ****************************************
    // write channel
    // ****************************************
    assign aw_hit = dec(aw_addr_q);
    assign wr_go = wr_st_q == TOS_WR_IDLE && aw_got_q && w_got_q;
    // only byte lane 0 carries register bits
    assign wr_opt0 = wr_go && w_strb_q[0] && aw_hit[0];
    assign wr_opt1 = wr_go && w_strb_q[0] && aw_hit[1];
    assign wr_ctrl = wr_go && w_strb_q[0] && aw_addr_q == `TOS_CTRL_ADDR;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_got_q <= 1'b0;
            aw_addr_q <= 32'h0;
            awready_q <= 1'b1;
        end
        else if (axi_req.awvalid && awready_q)
        begin
            aw_got_q <= 1'b1;
            aw_addr_q <= axi_req.awaddr;
            awready_q <= 1'b0;
        end
        else if (bvalid_q && axi_req.bready)
        begin
            aw_got_q <= 1'b0;
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            w_got_q <= 1'b0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            wready_q <= 1'b1;
        end
        else if (axi_req.wvalid && wready_q)
        begin
            w_got_q <= 1'b1;
            w_data_q <= axi_req.wdata;
            w_strb_q <= axi_req.wstrb;
            wready_q <= 1'b0;
        end
        else if (bvalid_q && axi_req.bready)
        begin
            w_got_q <= 1'b0;
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_st_q <= TOS_WR_IDLE;
            bvalid_q <= 1'b0;
            bresp_q <= `TOS_RESP_OKAY;
        end
        else
        begin
            case (wr_st_q)
                TOS_WR_IDLE:
                begin
                    if (wr_go)
                    begin
                        wr_st_q <= TOS_WR_RESP;
                        bvalid_q <= 1'b1;
                        bresp_q <= mapped(aw_addr_q) ? `TOS_RESP_OKAY : `TOS_RESP_SLVERR;
                    end
                end
                TOS_WR_RESP:
                begin
                    if (axi_req.bready)
                    begin
                        wr_st_q <= TOS_WR_IDLE;
                        bvalid_q <= 1'b0;
                    end
                end
                default:
                begin
                    wr_st_q <= TOS_WR_IDLE;
                    bvalid_q <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    function automatic logic [31:0] rd_val(input logic [31:0] a);
        logic [31:0] v;
        logic [2:0] h;
        v = 32'h0;
        h = dec(a);
        if (h[0])
        begin
            v[`TOS_OVF_BIT] = flag_q[F_OVF];
            v[`TOS_CCS0_BIT] = ccs0_q;
            v[`TOS_CCS1_BIT] = ccs1_q;
        end
        else if (h[1] && enc)
        begin
            v[`TOS_ESF_BIT] = esf_q;
            v[`TOS_EOF_BIT] = flag_q[F_EOF];
            v[`TOS_EUF_BIT] = flag_q[F_EUF];
        end
        else if (h[2] && tos_is_reload_mode(mode) && rld)
            v[`TOS_RSF_BIT] = flag_q[F_RSF];
        else if (a == `TOS_CTRL_ADDR)
            v[7:0] = ctrl_q;
        else if (a == `TOS_CNT_ADDR)
            v[CNT_W-1:0] = cnt;
        return v;
    endfunction

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_st_q <= TOS_RD_IDLE;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `TOS_RESP_OKAY;
        end
        else
        begin
            case (rd_st_q)
                TOS_RD_IDLE:
                begin
                    if (axi_req.arvalid)
                    begin
                        // reading has no side effect on any flag
                        rd_st_q <= TOS_RD_DATA;
                        arready_q <= 1'b0;
                        rvalid_q <= 1'b1;
                        rdata_q <= rd_val(axi_req.araddr);
                        rresp_q <= mapped(axi_req.araddr) ? `TOS_RESP_OKAY
                                                           : `TOS_RESP_SLVERR;
                    end
                end
                TOS_RD_DATA:
                begin
                    if (axi_req.rready)
                    begin
                        rd_st_q <= TOS_RD_IDLE;
                        arready_q <= 1'b1;
                        rvalid_q <= 1'b0;
                    end
                end
                default:
                begin
                    rd_st_q <= TOS_RD_IDLE;
                    arready_q <= 1'b1;
                    rvalid_q <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // option and control registers
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ccs0_q <= 1'b0;
            ccs1_q <= 1'b0;
        end
        else if (wr_opt0)
        begin
            ccs0_q <= w_data_q[`TOS_CCS0_BIT];
            ccs1_q <= w_data_q[`TOS_CCS1_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_q <= `TOS_CTRL_RESET;
        else if (wr_ctrl)
            ctrl_q <= w_data_q[7:0];
    end

    // select bits only steer the datapath in free-running mode
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cap_a_q <= 1'b0;
            cap_b_q <= 1'b0;
        end
        else
        begin
            cap_a_q <= ccs0_q && mode == `TOS_MODE_FREERUN;
            cap_b_q <= ccs1_q && mode == `TOS_MODE_FREERUN;
        end
    end

    // ****************************************
    // counter and status flags
    // ****************************************
    // a 1 written to a flag is simply not a clear
    assign ovf_wclr = wr_opt0 && !w_data_q[`TOS_OVF_BIT];
    // with hold on, a stop leaves the count where it was
    assign cnt_clr = ovf_wclr || stop_clr;

    tos_counter #(
        .CNT_W(CNT_W)
    ) u_counter (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clr(cnt_clr),
        .run(run),
        .up(evt.count_up),
        .down(evt.count_down),
        .match_clr(evt.match_clear),
        .cnt_q(cnt),
        .wrap_up(wrap_up),
        .wrap_down(wrap_down)
    );

    always_comb
    begin
        flag_set = 4'h0;
        flag_clr = 4'h0;
        flag_set[F_OVF] = wrap_up && ovm;
        flag_clr[F_OVF] = ovf_wclr;
        // encoder wraps leave the general flag alone
        flag_set[F_EOF] = wrap_up && enc;
        flag_set[F_EUF] = wrap_down && enc;
        flag_clr[F_EOF] = (wr_opt1 && !w_data_q[`TOS_EOF_BIT]) || stop_clr;
        flag_clr[F_EUF] = (wr_opt1 && !w_data_q[`TOS_EUF_BIT]) || stop_clr;
        flag_set[F_RSF] = evt.ccr_b_write;
        flag_clr[F_RSF] = evt.reload_done;
    end

    tos_flag #(
        .N(4)
    ) u_flags (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .set(flag_set),
        .clr(flag_clr),
        .flag_q(flag_q)
    );

    // direction is hardware-owned; writes to the status register do not touch it, but a stop without hold clears it
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            esf_q <= 1'b0;
        else if (stop_clr)
            esf_q <= 1'b0;
        else if (run && enc && evt.count_up)
            esf_q <= 1'b0;
        else if (run && enc && evt.count_down)
            esf_q <= 1'b1;
    end

    // interrupt pulse lands on the edge that sets the flag
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            int_q <= 1'b0;
        else
            int_q <= (wrap_up && (ovm || enc))
                || (wrap_down && (enc || mode == `TOS_MODE_TRIPWM));
    end

    // ****************************************
    // outputs
    // ****************************************
    assign axi_rsp.awready = awready_q;
    assign axi_rsp.wready = wready_q;
    assign axi_rsp.bvalid = bvalid_q;
    assign axi_rsp.bresp = bresp_q;
    assign axi_rsp.arready = arready_q;
    assign axi_rsp.rvalid = rvalid_q;
    assign axi_rsp.rdata = rdata_q;
    assign axi_rsp.rresp = rresp_q;
    assign overflow_interrupt = int_q;
    assign ccr_a_capture = cap_a_q;
    assign ccr_b_capture = cap_b_q;
    assign count_value = cnt;

endmodule // tos_top

`default_nettype wire

// ### src/tos_regs.svh
// register map, field positions, reset values and codes of the timer option block
`ifndef TOS_REGS_SVH
`define TOS_REGS_SVH

// register indices; byte address is four times the index
`define TOS_OPT0_IDX 32'h0ffff697
`define TOS_OPT1_IDX 32'hfffff698
`define TOS_OPT2_IDX 32'hfffff699
// block control and counter view, byte addresses
`define TOS_CTRL_ADDR 32'h00000100
`define TOS_CNT_ADDR 32'h00000104

// capture_overflow_option fields
`define TOS_OVF_BIT 0
`define TOS_CCS0_BIT 4
`define TOS_CCS1_BIT 5
// encoder_status_flags fields
`define TOS_ESF_BIT 0
`define TOS_EOF_BIT 1
`define TOS_EUF_BIT 2
// reload_pending_status fields
`define TOS_RSF_BIT 0
// control register fields
`define TOS_RUN_BIT 0
`define TOS_HOLD_BIT 1
`define TOS_RLD_BIT 2
`define TOS_MODE_LSB 4

`define TOS_REG_RESET 8'h00
`define TOS_CTRL_RESET 8'h00
`define TOS_RESP_OKAY 2'h0
`define TOS_RESP_SLVERR 2'h2

// operating mode codes
`define TOS_MODE_INTERVAL 4'h0
`define TOS_MODE_EXTEVT 4'h1
`define TOS_MODE_EXTTRIG 4'h2
`define TOS_MODE_ONESHOT 4'h3
`define TOS_MODE_PWM 4'h4
`define TOS_MODE_FREERUN 4'h5
`define TOS_MODE_PULSEW 4'h6
`define TOS_MODE_TRIPWM 4'h7
`define TOS_MODE_ENC_CMP 4'h8
`define TOS_MODE_ENC_CAP 4'h9
`define TOS_MODE_ENC_CC 4'ha
`define TOS_MODE_OFFSET 4'hb

`endif

// ### src/tos_pkg.sv
// types and mode decoding shared by the timer option block
`default_nettype none
`include "tos_regs.svh"

package tos_pkg;

    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } tos_axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tos_axil_rsp_s;

    typedef struct packed {
        logic count_up;
        logic count_down;
        logic match_clear;
        logic ccr_b_write;
        logic reload_done;
    } tos_evt_s;

    typedef enum logic [1:0] {TOS_WR_IDLE = 2'b01, TOS_WR_RESP = 2'b10} tos_wr_e;
    typedef enum logic [1:0] {TOS_RD_IDLE = 2'b01, TOS_RD_DATA = 2'b10} tos_rd_e;

    function automatic logic tos_is_encoder(input logic [3:0] m);
        return m == `TOS_MODE_ENC_CMP || m == `TOS_MODE_ENC_CAP || m == `TOS_MODE_ENC_CC;
    endfunction

    function automatic logic tos_is_ovf_mode(input logic [3:0] m);
        return m == `TOS_MODE_FREERUN || m == `TOS_MODE_PULSEW || m == `TOS_MODE_OFFSET;
    endfunction

    function automatic logic tos_is_reload_mode(input logic [3:0] m);
        return m == `TOS_MODE_EXTTRIG || m == `TOS_MODE_PWM || m == `TOS_MODE_OFFSET;
    endfunction

endpackage : tos_pkg

`default_nettype wire

// ### src/tos_flag.sv
// bank of hardware-set, software-cleared status flags
`default_nettype none

module tos_flag
    import tos_pkg::*;
#(
    parameter int N = 4
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // set and clear requests
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] clr,
    // flag state
    output logic [N-1:0] flag_q
);
    if (N < 1)
    begin : g_chk
        $error("tos_flag needs at least one flag");
    end

    for (genvar i = 0; i < N; i++)
    begin : g_flag
        // set wins so an event in the clearing cycle is not lost
        always_ff @(posedge core_clk or negedge arst_n)
        begin
            if (!arst_n)
                flag_q[i] <= 1'b0;
            else if (set[i])
                flag_q[i] <= 1'b1;
            else if (clr[i])
                flag_q[i] <= 1'b0;
        end
    end

endmodule // tos_flag

`default_nettype wire

// ### src/tos_counter.sv
// up/down counter with wrap events for the timer option block
`default_nettype none

module tos_counter
    import tos_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // control
    input wire logic clr,
    input wire logic run,
    input wire logic up,
    input wire logic down,
    input wire logic match_clr,
    // state and wrap events
    output logic [CNT_W-1:0] cnt_q,
    output logic wrap_up,
    output logic wrap_down
);
    if (CNT_W < 2 || CNT_W > 32)
    begin : g_chk
        $error("tos_counter width out of range");
    end

    localparam logic [CNT_W-1:0] CMAX = '1;
    logic live;

    assign live = run && !clr && !match_clr;
    // a compare-match clear at the top value is not a wrap
    assign wrap_up = live && up && cnt_q == CMAX;
    assign wrap_down = live && !up && down && cnt_q == '0;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            cnt_q <= '0;
        else if (clr || (run && match_clr))
            cnt_q <= '0;
        else if (run && up)
            cnt_q <= cnt_q + 1'b1;
        else if (run && down)
            cnt_q <= cnt_q - 1'b1;
    end

endmodule // tos_counter

`default_nettype wire

// ### dv/tos_top_properties.sv
// port-level checks of the timer option block
`default_nettype none

module tos_top_properties
    import tos_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // watched ports
    input wire tos_axil_req_s axi_req,
    input wire tos_axil_rsp_s axi_rsp,
    input wire tos_evt_s evt,
    input wire logic overflow_interrupt,
    input wire logic ccr_a_capture,
    input wire logic ccr_b_capture,
    input wire logic [CNT_W-1:0] count_value
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    irq_cause_a:
    assert property (overflow_interrupt |-> ($past(evt.count_up) && $past(count_value) == '1
        && count_value == '0) || ($past(evt.count_down) && $past(count_value) == '0
        && count_value == '1)) else $error("interrupt without a counter wrap");
    no_match_ovf_a:
    assert property (evt.match_clear && !evt.count_up && !evt.count_down |=> !overflow_interrupt)
        else $error("interrupt after a match clear");
    cnt_step_a:
    assert property (count_value != '0 && count_value == $past(count_value) + 1'b1
        |-> $past(evt.count_up)) else $error("counter rose without an up event");
    cnt_down_a:
    assert property (count_value != '0 && count_value != '1
        && count_value == $past(count_value) - 1'b1 |-> $past(evt.count_down))
        else $error("counter fell without a down event");
    wr_lat_a:
    assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
        |-> ##[1:2] axi_rsp.bvalid) else $error("write answer late");
    rd_lat_a:
    assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read answer late");
    rdata_hold_a:
    assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid
        && $stable(axi_rsp.rdata)) else $error("read data dropped early");
    cap_cause_a:
    assert property ($changed({ccr_a_capture, ccr_b_capture}) |-> $past(axi_rsp.bvalid)
        || $past(axi_rsp.bvalid, 2)) else $error("capture select moved without a write");
    // reset value check must see the reset itself, so no disable here
    reset_zero_a:
    assert property (disable iff (1'b0) !arst_n |-> count_value == '0 && !overflow_interrupt
        && !ccr_a_capture && !ccr_b_capture) else $error("outputs not cleared in reset");
endmodule // tos_top_properties

`default_nettype wire

// ### dv/tos_top_test.sv
// self-checking bench of the timer option block
`default_nettype none
`include "tos_regs.svh"

module tos_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import tos_pkg::*;
    // ****
    // stimulus and checking
    // ****
    localparam logic [31:0] OPT0 = `TOS_OPT0_IDX << 2;
    localparam logic [31:0] OPT1 = `TOS_OPT1_IDX << 2;
    localparam logic [31:0] OPT2 = `TOS_OPT2_IDX << 2;
    localparam logic [31:0] CTRL = `TOS_CTRL_ADDR;
    localparam tos_evt_s UP = 5'b10000;
    localparam tos_evt_s DN = 5'b01000;
    localparam tos_evt_s MC = 5'b00100;
    localparam tos_evt_s BW = 5'b00010;
    localparam tos_evt_s RL = 5'b00001;
    logic core_clk = 1'b0;
    logic arst_n;
    tos_axil_req_s axi_req = '0;
    tos_axil_rsp_s axi_rsp;
    tos_evt_s evt = '0;
    logic overflow_interrupt, ccr_a_capture, ccr_b_capture;
    logic [15:0] count_value;
    logic [33:0] exp_q[$];
    int miscompares = 0;
    int checks = 0;
    int irq_seen = 0;
    int seed = 43;

    tos_top #(.CNT_W(16)) dut (.core_clk(core_clk), .arst_n(arst_n), .axi_req(axi_req),
        .axi_rsp(axi_rsp), .evt(evt), .overflow_interrupt(overflow_interrupt),
        .ccr_a_capture(ccr_a_capture), .ccr_b_capture(ccr_b_capture),
        .count_value(count_value));

    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
        exp_q.push_back({r, 32'h0});
        @(posedge core_clk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= {24'h0, d};
        axi_req.wstrb <= 4'hf;
        axi_req.bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (!axi_rsp.bvalid);
        axi_req.bready <= 1'b0;
    endtask

    // rready is raised only once data shows, so the hold rule gets exercised
    task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
        exp_q.push_back({r, 24'h0, e});
        @(posedge core_clk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        do @(posedge core_clk); while (!axi_rsp.arready);
        axi_req.arvalid <= 1'b0;
        do @(posedge core_clk); while (!axi_rsp.rvalid);
        axi_req.rready <= 1'b1;
        @(posedge core_clk);
        axi_req.rready <= 1'b0;
    endtask

    task automatic pulse(input tos_evt_s e, input int n = 1);
        @(posedge core_clk);
        evt <= e;
        repeat (n) @(posedge core_clk);
        evt <= '0;
    endtask

    task automatic see(input string what, input logic [15:0] e, input logic [15:0] g);
        chk(what, {18'h0, e}, {18'h0, g});
    endtask

    always @(posedge core_clk)
    begin
        if (overflow_interrupt === 1'b1) irq_seen++;
        if ((axi_rsp.bvalid && axi_req.bready) || (axi_rsp.rvalid && axi_req.rready))
        begin
            if (exp_q.size() == 0)
                chk("spare response", '0, '1);
            else
                chk("response", exp_q.pop_front(), axi_rsp.bvalid ?
                    {axi_rsp.bresp, 32'h0} : {axi_rsp.rresp, axi_rsp.rdata});
        end
    end

    // whole run is about 70k cycles, dominated by the long up count
    initial
    begin
        #450us;
        miscompares++;
        complete_run();
    end

    initial
    begin
        logic [7:0] d;
        logic [3:0] rm[3];
        rm = '{4'h2, 4'h4, 4'hb};
        // a real falling edge so every flop is cleared before the first clock
        arst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(OPT0, 8'h00);
        rd(OPT1, 8'h00);
        rd(OPT2, 8'h00);
        rd(32'h200, 8'h00, 2'h2);
        wr(32'h200, 8'hff, 2'h2);
        repeat (2)
        begin
            d = 8'($random(seed));
            wr(OPT0, d);
            rd(OPT0, d & 8'h30);
        end
        wr(OPT0, 8'h20);
        @(negedge core_clk);
        see("capture outside free-run", 0, {ccr_b_capture, ccr_a_capture});
        wr(CTRL, 8'h50);
        rd(OPT0, 8'h20);
        see("capture b", 16'h2, {ccr_b_capture, ccr_a_capture});
        wr(OPT0, 8'h10);
        rd(OPT0, 8'h10);
        see("capture a", 16'h1, {ccr_b_capture, ccr_a_capture});
        wr(OPT0, 8'h00);
        wr(CTRL, 8'h51);
        pulse(UP, 65535);
        @(negedge core_clk);
        see("count top", 16'hffff, count_value);
        pulse(UP);
        @(negedge core_clk);
        see("count wrap", 16'h0, count_value);
        rd(OPT0, 8'h01);
        see("interrupts", 1, 16'(irq_seen));
        rd(OPT0, 8'h01);
        wr(OPT0, 8'h01);
        rd(OPT0, 8'h01);
        pulse(UP, 5);
        pulse(MC);
        pulse(UP, 3);
        wr(OPT0, 8'h00);
        rd(OPT0, 8'h00);
        see("count cleared", 16'h0, count_value);
        wr(CTRL, 8'h81);
        pulse(DN);
        @(negedge core_clk);
        see("count under", 16'hffff, count_value);
        rd(OPT1, 8'h05);
        pulse(UP | MC);
        @(negedge core_clk);
        see("match clear", 16'h0, count_value);
        pulse(DN);
        pulse(UP);
        rd(OPT1, 8'h06);
        rd(OPT0, 8'h00);
        see("interrupts", 4, 16'(irq_seen));
        wr(OPT1, 8'h07);
        rd(OPT1, 8'h06);
        wr(OPT1, 8'h02);
        rd(OPT1, 8'h02);
        wr(CTRL, 8'h51);
        rd(OPT1, 8'h00);
        wr(CTRL, 8'h81);
        rd(OPT1, 8'h02);
        wr(CTRL, 8'h83);
        pulse(DN);
        wr(CTRL, 8'h82);
        rd(OPT1, 8'h07);
        pulse(DN);
        see("held count", 16'hffff, count_value);
        wr(CTRL, 8'h83);
        pulse(DN);
        @(negedge core_clk);
        see("resumed count", 16'hfffe, count_value);
        rd(OPT1, 8'h07);
        wr(CTRL, 8'h80);
        rd(OPT1, 8'h00);
        see("stopped count", 16'h0, count_value);
        wr(CTRL, 8'h45);
        pulse(BW);
        rd(OPT2, 8'h01);
        foreach (rm[i])
        begin
            wr(CTRL, {rm[i], 4'h5});
            rd(OPT2, 8'h01);
        end
        wr(CTRL, 8'h55);
        rd(OPT2, 8'h00);
        wr(CTRL, 8'h41);
        rd(OPT2, 8'h00);
        wr(CTRL, 8'h45);
        pulse(RL);
        rd(OPT2, 8'h00);
        wr(CTRL, 8'h00);
        wr(OPT0, 8'h30);
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(OPT0, 8'h00);
        complete_run();
    end
endmodule // tos_top_test

bind tos_top tos_top_properties #(.CNT_W(CNT_W)) u_props (.core_clk(core_clk),
    .arst_n(arst_n), .axi_req(axi_req), .axi_rsp(axi_rsp), .evt(evt),
    .overflow_interrupt(overflow_interrupt), .ccr_a_capture(ccr_a_capture),
    .ccr_b_capture(ccr_b_capture), .count_value(count_value));

`default_nettype wire
